//--- snv_core.sv
`include "snv_defines.svh"
module snv_core #(
  parameter int ADDR_W = 13,
  parameter int DEPTH  = 8192
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 spi_sck_i,
  input  wire snv_pkg::snv_spi_in_t spi_i,
  input  wire logic                 write_protect_n_i,
  output snv_pkg::snv_spi_out_t     spi_o,
  output logic [7:0]                status_o
);
  import snv_pkg::*;

  // ***********************************
  // Nonvolatile state; array on the link clock, the rest in the system domain
  // ***********************************
  logic [7:0]        mem_r [DEPTH];
  logic              pin_en_r;
  logic [1:0]        bp_r;
  logic              latch_r;
  logic [1:0]        wp_sync_r;

  // ***********************************
  // Link domain (serial clock)
  // ***********************************
  snv_phase_t        phase_r;
  logic [2:0]        bit_cnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        cmd_r;
  logic [ADDR_W-1:0] addr_r;
  logic              halted_r;
  logic [7:0]        tx_r;
  logic              oe_r;
  logic              so_r;
  logic              st_tgl_r;
  logic [7:0]        st_data_r;
  logic              lset_tgl_r;
  logic              lclr_tgl_r;

  // Decoding used by both address check points
  function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    is_protected = (bp == 2'h3) ||
                   (bp == 2'h2 && a >= `SNV_HALF_BASE) ||
                   (bp == 2'h1 && a >= `SNV_QUARTER_BASE);
  endfunction

  // Link-side decode; latch and protect field are read directly as quasi-static config
  wire       cs_active  = !spi_i.cs_n;
  wire [7:0] bit_in     = {shift_r[6:0], spi_i.si};
  wire       byte_done  = (bit_cnt_r == `SNV_BYTE_LAST);
  wire       cmd_known  = (bit_in == `SNV_CMD_SET_LATCH) || (bit_in == `SNV_CMD_CLR_LATCH) ||
                          (bit_in == `SNV_CMD_STAT_READ) || (bit_in == `SNV_CMD_STAT_WRITE) ||
                          (bit_in == `SNV_CMD_MEM_READ)  || (bit_in == `SNV_CMD_MEM_WRITE);
  wire [ADDR_W-1:0] addr_inc  = (addr_r == `SNV_ADDR_LAST) ? '0 : addr_r + 1'b1;
  // Latch and protect field come from the system side; they only change between
  // frames, after the crossings of the previous frame have settled, so the link
  // reads them as static configuration while a frame is running
  wire       wr_blocked = is_protected(bp_r, addr_r) || !latch_r;
  // Byte commit into the array, straight from the link side
  wire       commit_w   = cs_active && byte_done && phase_r == SNV_ST_DATA &&
                          cmd_r == `SNV_CMD_MEM_WRITE && !halted_r && !wr_blocked;

  // Status byte assembly; unused bits tie to zero
  wire [7:0] status_w;
  assign status_w[`SNV_BIT_PIN_EN] = pin_en_r;
  assign status_w[6:4]             = 3'h0;
  assign status_w[`SNV_BIT_BP_HI]  = bp_r[1];
  assign status_w[`SNV_BIT_BP_LO]  = bp_r[0];
  assign status_w[`SNV_BIT_LATCH]  = latch_r;
  assign status_w[0]               = 1'b0;
  assign status_o = status_w;

  // Next read byte: memory or status
  wire [7:0] rd_byte = (cmd_r == `SNV_CMD_STAT_READ) ? status_w : mem_r[addr_r];

  // Input shifter and command phase, rising edge of serial clock; chip select resets it
  always_ff @(posedge spi_sck_i or posedge spi_i.cs_n) begin
    if (spi_i.cs_n) begin
      phase_r   <= SNV_ST_CMD;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      cmd_r     <= 8'h00;
      addr_r    <= '0;
      halted_r  <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r   <= bit_in;
      if (byte_done) begin
        case (phase_r)
          SNV_ST_CMD: begin
            cmd_r <= bit_in;
            if (!cmd_known) begin
              phase_r <= SNV_ST_IGNORE;
            end else if (bit_in == `SNV_CMD_MEM_READ || bit_in == `SNV_CMD_MEM_WRITE) begin
              phase_r <= SNV_ST_ADDR_HI;
            end else begin
              phase_r <= SNV_ST_DATA;
            end
          end
          SNV_ST_ADDR_HI: begin
            addr_r[ADDR_W-1:8] <= bit_in[ADDR_W-9:0];
            phase_r            <= SNV_ST_ADDR_LO;
          end
          SNV_ST_ADDR_LO: begin
            addr_r[7:0] <= bit_in;
            phase_r     <= SNV_ST_DATA;
          end
          SNV_ST_DATA: begin
            if (cmd_r == `SNV_CMD_MEM_READ) begin
              addr_r <= addr_inc;
            end else if (cmd_r == `SNV_CMD_MEM_WRITE && !halted_r) begin
              if (wr_blocked) begin
                halted_r <= 1'b1;
              end else begin
                addr_r <= addr_inc;
              end
            end else if (cmd_r != `SNV_CMD_MEM_WRITE) begin
              phase_r <= SNV_ST_IGNORE;
            end
          end
          default: phase_r <= SNV_ST_IGNORE;
        endcase
      end
    end
  end

  // Set-latch and status-write events raised by toggles on the eighth clock of their byte
  always_ff @(posedge spi_sck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_tgl_r   <= 1'b0;
      st_data_r  <= 8'h00;
      lset_tgl_r <= 1'b0;
    end else if (cs_active && byte_done) begin
      if (phase_r == SNV_ST_CMD && bit_in == `SNV_CMD_SET_LATCH) begin
        lset_tgl_r <= !lset_tgl_r;
      end
      if (phase_r == SNV_ST_DATA && cmd_r == `SNV_CMD_STAT_WRITE) begin
        st_tgl_r  <= !st_tgl_r;
        st_data_r <= bit_in;
      end
    end
  end

  // Latch clear request at chip-select rise after a write-class command
  always_ff @(posedge spi_i.cs_n or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lclr_tgl_r <= 1'b0;
    end else if (cmd_r == `SNV_CMD_CLR_LATCH || cmd_r == `SNV_CMD_STAT_WRITE ||
                 cmd_r == `SNV_CMD_MEM_WRITE) begin
      lclr_tgl_r <= !lclr_tgl_r;
    end
  end

  // Output shifter on falling edge; input ignored during data
  always_ff @(negedge spi_sck_i or posedge spi_i.cs_n) begin
    if (spi_i.cs_n) begin
      oe_r <= 1'b0;
      so_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (phase_r == SNV_ST_DATA &&
                 (cmd_r == `SNV_CMD_MEM_READ || cmd_r == `SNV_CMD_STAT_READ)) begin
      oe_r <= 1'b1;
      if (bit_cnt_r == 3'h0) begin
        so_r <= rd_byte[7];
        tx_r <= {rd_byte[6:0], 1'b0};
      end else begin
        so_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end else begin
      oe_r <= 1'b0;
    end
  end
  assign spi_o.so    = so_r;
  assign spi_o.so_oe = oe_r;

  // ***********************************
  // Event crossing into the system clock
  // ***********************************
  // Toggle events need three flops: two to settle, one to find the edge
  logic [2:0] st_sync_r, ls_sync_r, lc_sync_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_sync_r <= 3'h0;
      ls_sync_r <= 3'h0;
      lc_sync_r <= 3'h0;
      wp_sync_r <= 2'h0;
    end else if (clk_en_i) begin
      st_sync_r <= {st_sync_r[1:0], st_tgl_r};
      ls_sync_r <= {ls_sync_r[1:0], lset_tgl_r};
      lc_sync_r <= {lc_sync_r[1:0], lclr_tgl_r};
      wp_sync_r <= {wp_sync_r[0], write_protect_n_i};
    end
  end
  wire st_ev   = st_sync_r[2] ^ st_sync_r[1];
  wire lset_ev = ls_sync_r[2] ^ ls_sync_r[1];
  wire lclr_ev = lc_sync_r[2] ^ lc_sync_r[1];
  wire st_allowed = latch_r && !(pin_en_r && !wp_sync_r[1]);

  // ***********************************
  // Array storage, link domain
  // ***********************************
  // Written on the eighth rising serial clock of each data byte; kept on the
  // link clock so a back-to-back burst never outruns a crossing into the
  // system clock, and reads of the next byte see the same storage
  always_ff @(posedge spi_sck_i) begin
    if (commit_w) begin
      mem_r[addr_r] <= bit_in;
    end
  end

  // Status register and write latch; set wins over a simultaneous clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_r  <= 1'b0;
      pin_en_r <= 1'b0;
      bp_r     <= `SNV_BP_RESET;
    end else if (clk_en_i) begin
      if (st_ev && st_allowed) begin
        pin_en_r <= st_data_r[`SNV_BIT_PIN_EN];
        bp_r     <= {st_data_r[`SNV_BIT_BP_HI], st_data_r[`SNV_BIT_BP_LO]};
      end
      if (lset_ev) begin
        latch_r <= 1'b1;
      end else if (lclr_ev) begin
        latch_r <= 1'b0;
      end
    end
  end

  // ***********************************
  // Assertions
  // ***********************************
  latch_set_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && lset_ev |=> latch_r) else $error("latch not set");
  latch_clr_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && lclr_ev && !lset_ev |=> !latch_r) else $error("latch not cleared");
  zero_bits_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    status_o[0] == 1'b0 && status_o[6:4] == 3'h0) else $error("fixed bits nonzero");
  pin_block_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && st_ev && pin_en_r && !wp_sync_r[1] |=> $stable(bp_r) && pin_en_r)
    else $error("status written while pin protected");
  no_latch_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !latch_r && !(clk_en_i && lset_ev) |=> $stable(bp_r) && $stable(pin_en_r))
    else $error("status changed without latch");
  // Memory write byte completing on the link
  sequence wr_byte_s;
    cs_active && byte_done && phase_r == SNV_ST_DATA && cmd_r == `SNV_CMD_MEM_WRITE;
  endsequence
  // Status write byte completing on the link
  sequence st_byte_s;
    cs_active && byte_done && phase_r == SNV_ST_DATA && cmd_r == `SNV_CMD_STAT_WRITE;
  endsequence
  // Protected address keeps its old contents
  prot_commit_a: assert property (@(posedge spi_sck_i) disable iff (!reset_n_i)
    wr_byte_s ##0 is_protected(bp_r, addr_r)
    |=> mem_r[$past(addr_r)] == $past(mem_r[addr_r]))
    else $error("protected byte committed");
  // Unprotected byte with latch set lands at its address
  commit_data_a: assert property (@(posedge spi_sck_i) disable iff (!reset_n_i)
    wr_byte_s ##0 (!halted_r && latch_r && !is_protected(bp_r, addr_r))
    |=> mem_r[$past(addr_r)] == $past(bit_in))
    else $error("byte not committed");
  // Byte without latch leaves the array alone
  nolatch_mem_a: assert property (@(posedge spi_sck_i) disable iff (!reset_n_i)
    wr_byte_s ##0 !latch_r
    |=> mem_r[$past(addr_r)] == $past(mem_r[addr_r]))
    else $error("byte written without latch");
  // Status byte is raised toward the system side
  st_toggle_a: assert property (@(posedge spi_sck_i) disable iff (!reset_n_i)
    st_byte_s
    |=> st_tgl_r != $past(st_tgl_r) && st_data_r == $past(bit_in))
    else $error("status byte not passed on");
  // Read address rolls over at the top
  addr_wrap_a: assert property (@(posedge spi_sck_i) disable iff (!reset_n_i)
    cs_active && byte_done && phase_r == SNV_ST_DATA && cmd_r == `SNV_CMD_MEM_READ &&
    addr_r == `SNV_ADDR_LAST
    |=> addr_r == {ADDR_W{1'b0}})
    else $error("address did not wrap");
  // Ignored frame keeps the output released
  ignore_quiet_a: assert property (@(posedge spi_sck_i) disable iff (spi_i.cs_n)
    phase_r == SNV_ST_IGNORE |-> !spi_o.so_oe)
    else $error("output driven in ignored frame");
  // Deselect parks the command decoder
  idle_phase_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    spi_i.cs_n |-> phase_r == SNV_ST_CMD && !halted_r)
    else $error("decoder not parked");
  // Output driven only for read commands
  oe_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    spi_o.so_oe |-> (cmd_r == `SNV_CMD_MEM_READ || cmd_r == `SNV_CMD_STAT_READ))
    else $error("output driven outside a read");
  // Latch holds until a clear event
  latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    latch_r && !(clk_en_i && lclr_ev && !lset_ev) |=> latch_r)
    else $error("latch dropped on its own");
  // Latch rises only from the set command
  latch_rise_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(latch_r) |-> $past(clk_en_i && lset_ev))
    else $error("latch set without command");
  // Latch falls only from a clear event
  latch_fall_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(latch_r) |-> $past(clk_en_i && lclr_ev))
    else $error("latch cleared without event");
  // Allowed status write takes the supplied bits
  st_update_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && st_ev && st_allowed
    |=> pin_en_r == $past(st_data_r[`SNV_BIT_PIN_EN]) &&
        bp_r == {$past(st_data_r[`SNV_BIT_BP_HI]), $past(st_data_r[`SNV_BIT_BP_LO])})
    else $error("status write not applied");
  // Protection bits stay put between status writes
  cfg_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !(clk_en_i && st_ev) |=> $stable(pin_en_r) && $stable(bp_r))
    else $error("protection bits moved");
  // Low clock enable freezes system state
  freeze_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !clk_en_i |=> $stable(latch_r) && $stable(bp_r) && $stable(ls_sync_r))
    else $error("state moved while frozen");
  // Protect pin passes its second flop
  wp_sync_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i |=> wp_sync_r[1] == $past(wp_sync_r[0]))
    else $error("protect pin sync broken");
  halt_addr_a: assert property (@(posedge spi_sck_i) disable iff (spi_i.cs_n)
    halted_r |=> $stable(addr_r)) else $error("address moved after halt");
  idle_out_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    spi_i.cs_n |-> !spi_o.so_oe) else $error("output driven while deselected");
endmodule

//--- snv_defines.svh
`ifndef SNV_DEFINES_SVH
`define SNV_DEFINES_SVH
// How it works
// - Write latch starts cleared after reset
// - Set-latch command sets latch, shown in status
// - Status write clears latch flag at frame end
// - Latch clears when write commands end
// - Clear-latch command clears the latch
// - Status bits: 7 pin-enable, 3/2 protect, 1 latch
// - Bits 0, 4-6 read zero, unwritable
// - Block-protect bits kept nonvolatile, default zero
// - Protect field selects quarter, half or all
// - Pin-enable plus low pin blocks status write
// - Array writes gated by latch and protect field
// - Protect pin never blocks array writes
// - Status read shifts out status byte
// - Status write updates three bits, ends write
// - Two address bytes, low 13 bits used
// - Address increments per byte, wraps to zero
// - Each full byte committed after eighth clock
// - Protected address stops burst and increment
// - Read data MSB first, input ignored
// - Chip-select high ends access, output released
// - Latch set/clear and status read codes
// - Status write, read and write codes
// - First byte is the only command
// - Unknown command ignored until next select
`define SNV_CMD_SET_LATCH    8'h06
`define SNV_CMD_CLR_LATCH    8'h04
`define SNV_CMD_STAT_READ    8'h05
`define SNV_CMD_STAT_WRITE   8'h01
`define SNV_CMD_MEM_READ     8'h03
`define SNV_CMD_MEM_WRITE    8'h02
`define SNV_BIT_PIN_EN       7
`define SNV_BIT_BP_HI        3
`define SNV_BIT_BP_LO        2
`define SNV_BIT_LATCH        1
`define SNV_QUARTER_BASE     13'h1800
`define SNV_HALF_BASE        13'h1000
`define SNV_ADDR_LAST        13'h1FFF
`define SNV_BP_RESET         2'h0
`define SNV_BYTE_LAST        3'h7
`endif

//--- snv_master.sv
module snv_master (
  output snv_pkg::snv_spi_in_t       spi_o,
  output logic                       sck_o,
  input  wire snv_pkg::snv_spi_out_t spi_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import snv_pkg::*;

  // ****
  // Bus master model, mode 0, 6 ns serial clock
  // ****
  logic [7:0] rx_r;

  // Deselected and clock parked low between frames
  initial begin
    spi_o = '{cs_n: 1'b1, si: 1'b0};
    sck_o = 1'b0;
  end

  // One frame: bits MSB first, output pin seen inverted while not driven
  task automatic xfer(input logic [47:0] tx, input int nbits, output logic [7:0] rx);
    spi_o.cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_o.si = tx[47-i];
      #3 sck_o = 1'b1;
      rx_r = {rx_r[6:0], spi_i.so_oe ? spi_i.so : ~spi_i.so}; // Unpulled line shows the inverse
      #3 sck_o = 1'b0;
    end
    #3 spi_o.cs_n = 1'b1;
    spi_o.si = ~spi_o.si; // Stale data line after release
    rx = rx_r;
  endtask
endmodule

//--- snv_pkg.sv
package snv_pkg;
  typedef enum logic [2:0] {
    SNV_ST_CMD, SNV_ST_ADDR_HI, SNV_ST_ADDR_LO, SNV_ST_DATA, SNV_ST_IGNORE
  } snv_phase_t;
  // Serial pins as seen by the device
  typedef struct packed {
    logic cs_n;
    logic si;
  } snv_spi_in_t;
  typedef struct packed {
    logic so;
    logic so_oe;
  } snv_spi_out_t;
endpackage

//--- test_snv_core.sv
module test_snv_core;
  timeunit 1ns;
  timeprecision 1ps;
  import snv_pkg::*;

  // ****
  // Bench signals, clock and run control
  // ****
  logic         sys_clk;
  logic         reset_n;
  logic         wp_n;
  logic         clk_en;
  logic         sck;
  snv_spi_in_t  spi_in;
  snv_spi_out_t spi_out;
  logic [7:0]   status;
  logic [7:0]   rx;
  int           bad_count = 0;
  int           n_compared = 0;
  int           cycles = 0;

`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", what, exp, got); end end

  snv_core i_snv_core (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en),
    .spi_sck_i(sck), .spi_i(spi_in), .write_protect_n_i(wp_n), .spi_o(spi_out),
    .status_o(status));
  snv_master i_snv_master (.spi_o(spi_in), .sck_o(sck), .spi_i(spi_out));

  // System clock, 20 ns
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Frame, then room for the crossings to settle
  task automatic op(input logic [47:0] tx, input int nbits);
    i_snv_master.xfer(tx, nbits, rx);
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic wr_mem(input logic [12:0] a, input logic [15:0] d, input int nbytes);
    op({8'h06, 40'h0}, 8);
    op({8'h02, 3'b111, a, d, 8'h00}, 24 + 8 * nbytes);
  endtask
  task automatic rd_mem(input logic [12:0] a, input int nbytes);
    op({8'h03, 3'b111, a, 24'hFFFFFF}, 24 + 8 * nbytes);
  endtask
  task automatic wr_stat(input logic [7:0] v);
    op({8'h06, 40'h0}, 8);
    op({8'h01, v, 32'h0}, 16);
  endtask

  // ****
  // Test sequence
  // ****
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    clk_en = 1'b1;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("status after reset", 8'h00, status)
    op({8'h05, 40'h0}, 16);
    `CHK("status read", 8'h00, rx)
    op({8'h06, 8'h04, 32'h0}, 16);
    `CHK("latch set", 8'h02, status)
    op({8'h05, 40'h0}, 16);
    `CHK("status read latch", 8'h02, rx)
    op({8'h04, 40'h0}, 8);
    `CHK("latch clear", 8'h00, status)
    wr_mem(13'h1FFF, 16'h1122, 2);
    `CHK("latch after write", 8'h00, status)
    wr_mem(13'h1800, 16'h6600, 1);
    op({8'h02, 3'b000, 13'h1800, 16'h7700, 8'h00}, 32);
    rd_mem(13'h1FFF, 1);
    `CHK("mem top", 8'h11, rx)
    rd_mem(13'h1FFF, 2);
    `CHK("mem wrap", 8'h22, rx)
    rd_mem(13'h1800, 1);
    `CHK("mem no latch", 8'h66, rx)
    wr_stat(8'hFF);
    `CHK("status write", 8'h8C, status)
    wr_mem(13'h0000, 16'h9900, 1);
    rd_mem(13'h0000, 1);
    `CHK("mem all protected", 8'h22, rx)
    wp_n = 1'b0;
    wr_stat(8'h00);
    `CHK("status pin block", 8'h8C, status & 8'hFD)
    wp_n = 1'b1;
    wr_stat(8'h84);
    `CHK("status quarter", 8'h84, status)
    wp_n = 1'b0;
    wr_mem(13'h17FF, 16'h3344, 2);
    rd_mem(13'h17FF, 1);
    `CHK("mem pin ignored", 8'h33, rx)
    rd_mem(13'h1800, 1);
    `CHK("mem burst halted", 8'h66, rx)
    clk_en = 1'b0;
    op({8'h06, 40'h0}, 8);
    `CHK("latch frozen", 8'h84, status)
    clk_en = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK("latch after enable", 8'h86, status)
    op({8'h04, 40'h0}, 8);
    op({8'hAA, 8'h06, 32'h0}, 16);
    `CHK("unknown opcode", 8'h84, status)
    `CHK("output released", 8'hFF, rx)
    `CHK("output enable idle", 1'b0, spi_out.so_oe)
    conclude();
  end
endmodule
